/* design/tcsm_pkg.sv */
package tcsm_pkg;

    // Register locations inside control page 0.
    localparam logic [7:0] TCSM_PAGE_CFG = 8'h00;
    localparam logic [7:0] TCSM_OFS_CH4 = 8'h0e;
    localparam logic [7:0] TCSM_OFS_CH5 = 8'h0f;
    localparam logic [7:0] TCSM_OFS_CH6 = 8'h10;

    // Reset values of the three slot registers.
    localparam logic [7:0] TCSM_RST_CH4 = 8'h03;
    localparam logic [7:0] TCSM_RST_CH5 = 8'h04;
    localparam logic [7:0] TCSM_RST_CH6 = 8'h05;

    // Field layout of a slot register.
    localparam int TCSM_LINE_BIT = 6;
    localparam int TCSM_SLOT_MSB = 5;
    localparam int TCSM_SLOT_W = 6;
    localparam logic [7:0] TCSM_WR_MASK = 8'h7f;

    // Slots per half-frame in two-half framing.
    localparam logic [5:0] TCSM_HALF_SLOTS = 6'h20;
    localparam int TCSM_NUM_CH = 3;
    localparam int TCSM_SAMPLE_W = 32;

    // Frame formats of the serial audio port.
    typedef enum logic [1:0] {
        TCSM_FMT_TDM = 2'h0,
        TCSM_FMT_I2S = 2'h1,
        TCSM_FMT_LEFT_JUSTIFIED = 2'h2
    } tcsm_fmt_t;

    // Control port access.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcsm_ctl_req_t;

    // One sample entering the mapper.
    typedef struct packed {
        logic [1:0] chan;
        logic [TCSM_SAMPLE_W-1:0] data;
    } tcsm_sample_t;

    // Placement of one sample in the outgoing frame.
    typedef struct packed {
        logic line_sel;
        logic right_half;
        logic [5:0] slot;
        logic [TCSM_SAMPLE_W-1:0] data;
    } tcsm_placed_t;

endpackage

/* design/tcsm_fifo.sv */
`timescale 1ns/1ps
module tcsm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff, nxt_wp;
    logic [AW-1:0] rp_ff, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // Full and empty come straight from the occupancy count.
    always_comb begin
        o_in_ready = (cnt_ff != AW'(0) + (AW+1)'(DEPTH)) ;
        o_out_valid = (cnt_ff != '0);
        o_out_data = mem_ff[rp_ff];
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        nxt_wp = push ? wp_ff + AW'(1) : wp_ff;
        nxt_rp = pop ? rp_ff + AW'(1) : rp_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage has no reset; only the pointers and the occupancy count need a known value.
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wp_ff] <= i_in_data;
        end
        if (i_sys_rst) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

/* design/tcsm_mapper.sv */
`timescale 1ns/1ps
// Overview of operation
// - Line bit routes to primary or secondary.
// - TDM slot equals 6-bit field value.
// - Two-half framing: 0..31 is left slot.
// - Two-half framing: 32..63 is right, minus 32.
// - Channel 4 register at 0x0E resets 3.
// - Channel 5 register at 0x0F resets 4.
// - Channel 6 register at 0x10 resets 5.
module tcsm_mapper
    import tcsm_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire tcsm_ctl_req_t i_ctl,
    output logic [7:0] o_ctl_rdata,
    output logic o_ctl_rvalid,
    input wire tcsm_fmt_t i_fmt,
    input wire logic i_smp_valid,
    output logic o_smp_ready,
    input wire tcsm_sample_t i_smp,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output tcsm_placed_t o_out
);

    ////////////////////////////////////////////////////////////////////////
    // Slot configuration registers.

    logic [7:0] cfg_ff [TCSM_NUM_CH];
    logic [7:0] nxt_cfg [TCSM_NUM_CH];
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic pg_hit;

    localparam logic [7:0] OFS [TCSM_NUM_CH] =
        '{TCSM_OFS_CH4, TCSM_OFS_CH5, TCSM_OFS_CH6};
    localparam logic [7:0] RST [TCSM_NUM_CH] =
        '{TCSM_RST_CH4, TCSM_RST_CH5, TCSM_RST_CH6};

    assign pg_hit = (i_ctl.page == TCSM_PAGE_CFG);

    // Writes keep bit 7 cleared so it always reads back as zero.
    always_comb begin
        nxt_rdata = 8'h00;
        nxt_rvalid = i_ctl.rd;
        for (int k = 0; k < TCSM_NUM_CH; k++) begin
            nxt_cfg[k] = cfg_ff[k];
            if (i_ctl.wr && pg_hit && i_ctl.addr == OFS[k]) begin
                nxt_cfg[k] = i_ctl.wdata & TCSM_WR_MASK;
            end
            if (i_ctl.rd && pg_hit && i_ctl.addr == OFS[k]) begin
                nxt_rdata = cfg_ff[k] & TCSM_WR_MASK;
            end
        end
    end

    // Reset values per channel; unmapped reads answer zero.
    always_ff @(posedge i_clk) begin
        for (int k = 0; k < TCSM_NUM_CH; k++) begin
            if (i_sys_rst) begin
                cfg_ff[k] <= RST[k];
            end else begin
                cfg_ff[k] <= nxt_cfg[k];
            end
        end
        if (i_sys_rst) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign o_ctl_rdata = rdata_ff;
    assign o_ctl_rvalid = rvalid_ff;

    ////////////////////////////////////////////////////////////////////////
    // Sample buffer; back-pressure from the frame side stalls the source.

    logic fifo_valid;
    logic fifo_pop;
    tcsm_sample_t fifo_data;

    tcsm_fifo #(
        .WIDTH($bits(tcsm_sample_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_smp_valid),
        .o_in_ready(o_smp_ready),
        .i_in_data(i_smp),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Placement stage: one registered output word.

    tcsm_placed_t out_ff, nxt_out;
    logic ovalid_ff, nxt_ovalid;
    logic [7:0] sel_cfg;
    logic [5:0] fld;

    // Stage accepts a new sample when empty or being drained.
    assign fifo_pop = !ovalid_ff || i_out_ready;

    // Channel codes 0..2 are channels 4..6; code 3 falls back to channel 4.
    always_comb begin
        sel_cfg = (fifo_data.chan < 2'(TCSM_NUM_CH)) ?
            cfg_ff[fifo_data.chan] : cfg_ff[0];
        fld = sel_cfg[TCSM_SLOT_MSB:0];
        nxt_out = out_ff;
        nxt_ovalid = ovalid_ff && !i_out_ready;
        if (fifo_pop && fifo_valid) begin
            nxt_ovalid = 1'b1;
            nxt_out.data = fifo_data.data;
            nxt_out.line_sel = sel_cfg[TCSM_LINE_BIT];
            if (i_fmt == TCSM_FMT_TDM) begin
                nxt_out.right_half = 1'b0;
                nxt_out.slot = fld;
            end else if (fld < TCSM_HALF_SLOTS) begin
                nxt_out.right_half = 1'b0;
                nxt_out.slot = fld;
            end else begin
                nxt_out.right_half = 1'b1;
                nxt_out.slot = fld - TCSM_HALF_SLOTS;
            end
        end
    end

    // The held word stays put while the frame side stalls.
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            out_ff <= '0;
            ovalid_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            ovalid_ff <= nxt_ovalid;
        end
    end

    assign o_out_valid = ovalid_ff;
    assign o_out = out_ff;

endmodule

/* tb/tcsm_props.sv */
`timescale 1ns/1ps
module tcsm_props
    import tcsm_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire tcsm_ctl_req_t i_ctl,
    input wire logic [7:0] o_ctl_rdata,
    input wire logic o_ctl_rvalid,
    input wire tcsm_fmt_t i_fmt,
    input wire logic i_smp_valid,
    input wire logic o_smp_ready,
    input wire tcsm_sample_t i_smp,
    input wire logic o_out_valid,
    input wire logic i_out_ready,
    input wire tcsm_placed_t o_out
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic hit;
    // Only page 0 offsets 0x0e to 0x10 hold slot registers.
    assign hit = i_ctl.page == 8'h00 && i_ctl.addr inside {[8'h0e:8'h10]};
    a_read_answer: assert property (i_ctl.rd |=> o_ctl_rvalid)
        else $error("read not answered");
    a_bit7_zero: assert property (o_ctl_rvalid |-> !o_ctl_rdata[7])
        else $error("reserved bit set");
    a_unmapped_zero: assert property (i_ctl.rd && !hit |=> o_ctl_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_write_readback: assert property (i_ctl.wr && hit ##1 i_ctl.rd && hit
        && i_ctl.addr == $past(i_ctl.addr) |=>
        o_ctl_rdata == ($past(i_ctl.wdata, 2) & 8'h7f))
        else $error("readback mismatch");
    a_tdm_left: assert property (o_out_valid && i_fmt == TCSM_FMT_TDM
        |-> !o_out.right_half)
        else $error("tdm sample in right half");
    a_half_range: assert property (o_out_valid && i_fmt != TCSM_FMT_TDM
        |-> o_out.slot < 6'h20)
        else $error("half-frame slot too big");
    a_out_holds: assert property (o_out_valid && !i_out_ready
        |=> o_out_valid && $stable(o_out))
        else $error("placed sample dropped");
    a_reset_idle: assert property ($fell(i_sys_rst)
        |-> o_smp_ready && !o_out_valid && !o_ctl_rvalid)
        else $error("not idle after reset");
endmodule
bind tcsm_mapper tcsm_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_tcsm_props (.*);

/* tb/tcsm_host.sv */
`timescale 1ns/1ps
module tcsm_host (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_hold,
    output logic o_ready
);
    logic [7:0] lfsr_ff;
    // Random stalls keep the output stage under pressure while draining.
    always_ff @(posedge i_clk) begin
        lfsr_ff <= i_sys_rst ? 8'h5a :
            {lfsr_ff[6:0], ^(lfsr_ff & 8'hb8)};
        o_ready <= !i_sys_rst && !i_hold && lfsr_ff[0];
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_top
    import tcsm_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_sys_rst, i_smp_valid, i_out_ready, hold;
    logic o_smp_ready, o_out_valid, o_ctl_rvalid;
    logic [7:0] o_ctl_rdata;
    logic [31:0] seed = 32'h3485b5e0;
    logic [7:0] cfg [3];
    logic [7:0] rq [$];
    tcsm_placed_t sq [$];
    tcsm_ctl_req_t i_ctl;
    tcsm_fmt_t i_fmt;
    tcsm_sample_t i_smp;
    tcsm_placed_t o_out;
    int n_fail = 0;
    int num_checks = 0;
    always #5 i_clk = ~i_clk;
    tcsm_mapper u_tcsm_mapper (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_ctl(i_ctl), .o_ctl_rdata(o_ctl_rdata), .o_ctl_rvalid(o_ctl_rvalid),
        .i_fmt(i_fmt), .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready),
        .i_smp(i_smp), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
        .o_out(o_out));
    tcsm_host u_tcsm_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_hold(hold), .o_ready(i_out_ready));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Where a sample must land, given the register model and format.
    function automatic tcsm_placed_t place(logic [1:0] c, logic [31:0] d);
        tcsm_placed_t p;
        p.line_sel = cfg[c][6];
        p.right_half = i_fmt != TCSM_FMT_TDM && cfg[c][5];
        p.slot = i_fmt == TCSM_FMT_TDM ? cfg[c][5:0] : {1'b0, cfg[c][4:0]};
        p.data = d;
        return p;
    endfunction
    // One control cycle; the caller idles the port when done.
    task automatic acc(logic w, logic r, logic [7:0] pg, a, d);
        logic h;
        h = pg == 8'h00 && a inside {[8'h0e:8'h10]};
        @(posedge i_clk);
        i_ctl <= '{w, r, pg, a, d};
        if (r) rq.push_back(h ? cfg[a - 8'h0e] : 8'h00);
        if (w && h) cfg[a - 8'h0e] = d & 8'h7f;
    endtask
    // Fill while the host stalls, then let it drain with random stalls.
    task automatic fill();
        int n;
        logic [1:0] c;
        logic [31:0] d;
        n = 0;
        for (int k = 0; k < 40; k++) begin
            c = 2'(rnd() % 3);
            d = rnd();
            @(posedge i_clk);
            i_smp_valid <= 1'b1;
            i_smp <= {c, d};
            @(negedge i_clk);
            if (!o_smp_ready) break;
            sq.push_back(place(c, d));
            n++;
        end
        `CHK(n, 17)
        @(posedge i_clk);
        i_smp_valid <= 1'b0;
        hold <= 1'b0;
        for (int t = 0; t < 400 && sq.size() > 0; t++) @(posedge i_clk);
        `CHK(sq.size(), 0)
        hold <= 1'b1;
    endtask
    task automatic report_and_stop();
        if (n_fail == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Results are checked in issue order as they appear.
    always @(posedge i_clk) begin
        if (o_ctl_rvalid) `CHK(o_ctl_rdata, rq.pop_front())
        if (o_out_valid && i_out_ready) `CHK(o_out, sq.pop_front())
    end
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        i_sys_rst = 1'b1;
        i_ctl = '0;
        i_fmt = TCSM_FMT_TDM;
        i_smp_valid = 1'b0;
        i_smp = '0;
        hold = 1'b1;
        cfg = '{8'h03, 8'h04, 8'h05};
        repeat (6) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (int a = 13; a < 18; a++) acc(0, 1, 0, 8'(a), 0);
        acc(0, 1, 1, 8'h0e, 0);
        acc(1, 0, 0, 8'h0f, 8'hff);
        acc(0, 1, 0, 8'h0f, 0);
        for (int f = 0; f < 3; f++) begin
            for (int a = 0; a < 3; a++) begin
                acc(1, 0, 0, 8'(a + 14), f == 0 ? 8'(8'hff >> (a * 2)) : 8'(rnd()));
            end
            for (int a = 14; a < 17; a++) acc(0, 1, 0, 8'(a), 0);
            acc(0, 0, 0, 0, 0);
            i_fmt <= tcsm_fmt_t'((f + 1) % 3);
            fill();
        end
        report_and_stop();
    end
endmodule
